// ==== core/act_adc_ctrl.sv ====
// converter control, reference and temperature indicator register block
//
// Summary of operation
// RQ1: range bit set selects temperature high range
// RQ2: range bit clear selects temperature low range
// RQ3: ten-bit successive approximation result into result pair
// RQ4: six-bit channel field drives sample multiplexer
// RQ5: ports a-f, temp, dac, fixed ref, ground
// RQ6: software waits settling after channel change
// RQ7: positive reference: pin, supply, fixed 2x, 4x
// RQ8: negative reference bit: pin or ground
// RQ9: clock field picks divider ratio or rc
// RQ10: conversion lasts eleven and a half periods
// RQ11: completion raises interrupt, wakes from sleep
// RQ12: divided clocks follow system clock, rc independent
// RQ13: software waits acquisition after temp selection
// RQ14: software averages ten temperature readings
// RQ15: software selects ground before lower channel
// RQ16: indicator enable bit powers sensor on/off
// RQ17: go bit starts conversion when converter on
// RQ18: completion clears go, sets flag, updates results
// RQ19: format bit picks left or right justification
// RQ20: divider counts system cycles, restarts each conversion
// RQ21: temperature input valid only while indicator enabled
`timescale 1ns/1ps
module act_adc_ctrl (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_rc_osc,
   input wire logic i_cmp_above,
   input wire logic i_fvr_ready,
   input wire logic i_sleep,
   output logic [5:0] o_chan_sel,
   output logic o_chan_legal,
   output logic o_sample,
   output logic [act_pkg::RES_BITS-1:0] o_sar_code,
   output logic [1:0] o_pos_ref_sel,
   output logic o_neg_ref_sel,
   output logic o_fvr_enable,
   output logic [1:0] o_conv_ref_gain,
   output logic [1:0] o_comp_ref_gain,
   output logic o_temp_enable,
   output logic o_temp_high_range,
   output logic o_temp_valid,
   output logic o_conv_active,
   output logic o_irq,
   output logic o_wake
);
   import act_pkg::*;

   act_tad_if tad ();

   logic ack_q;
   logic [7:0] rdata_q;
   logic [7:0] ctrl0_q;
   logic [7:0] ctrl1_q;
   logic [7:0] vref_q;
   logic [9:0] res_q;
   logic [9:0] sar_q;
   logic [9:0] sar_d;
   logic [4:0] hc_q;
   logic flag_q;
   logic ie_q;
   logic cmp_m_q;
   logic cmp_s_q;
   logic rdy_m_q;
   logic rdy_s_q;
   logic legal_q;
   logic tvalid_q;
   act_state_type state_q;
   act_state_type state_d;

   // ----------------------------------------------------------------
   // avalon slave: one wait state, then the access completes
   // ----------------------------------------------------------------
   wire req = i_avs_read || i_avs_write;
   wire wr = i_avs_write && ack_q;
   wire [7:0] wdat = i_avs_writedata[7:0];
   wire hit_c0 = (i_avs_address == OFS_CTRL0);
   wire hit_c1 = (i_avs_address == OFS_CTRL1);
   wire hit_vr = (i_avs_address == OFS_VREF);
   wire hit_hi = (i_avs_address == OFS_RES_HI);
   wire hit_lo = (i_avs_address == OFS_RES_LO);
   wire hit_irq = (i_avs_address == OFS_IRQ);
   wire wr_c0 = wr && hit_c0;
   wire wr_irq = wr && hit_irq;
   assign o_avs_waitrequest = req && !ack_q;
   assign o_avs_readdata = {24'h000000, rdata_q};

   // ----------------------------------------------------------------
   // conversion control decode
   // ----------------------------------------------------------------
   wire busy = (state_q == ST_CONVERT);
   wire conv_on = ctrl0_q[C0_ON_BIT];
   wire fmt_right = ctrl1_q[C1_FM_BIT];
   wire use_rc = (ctrl1_q[C1_CS_LSB +: 2] == CS_RC_LOW);
   // go only counts once the converter was already on
   wire go_req = wr_c0 && wdat[C0_GO_BIT] && wdat[C0_ON_BIT]
      && conv_on; // RQ17
   wire start = go_req && !busy;
   // sleep only survives with the rc clock, as that keeps running
   wire abort = busy && ((wr_c0 && (!wdat[C0_GO_BIT]
      || !wdat[C0_ON_BIT])) || (i_sleep && !use_rc));
   wire done = busy && tad.half_tick && (hc_q == HALF_LAST); // RQ10
   wire decide = busy && tad.half_tick && hc_q[0]
      && (hc_q <= HALF_LAST_BIT);
   wire [3:0] bit_idx = 4'(RES_BITS - 1) - 4'(hc_q[4:1]);

   // ----------------------------------------------------------------
   // read data selection, with result justification
   // ----------------------------------------------------------------
   wire [7:0] rd_c0 = {ctrl0_q[7:2], busy, conv_on};
   wire [7:0] rd_vr = {vref_q[7], rdy_s_q, vref_q[5:0]};
   wire [7:0] rd_hi = fmt_right ? {6'h00, res_q[9:8]}
      : res_q[9:2]; // RQ19
   wire [7:0] rd_lo = fmt_right ? res_q[7:0]
      : {res_q[1:0], 6'h00}; // RQ19
   wire [7:0] rd_irq = {6'h00, ie_q, flag_q};
   wire [7:0] rd_mux = hit_c0 ? rd_c0 : hit_c1 ? ctrl1_q
      : hit_vr ? rd_vr : hit_hi ? rd_hi : hit_lo ? rd_lo
      : hit_irq ? rd_irq : 8'h00;

   // ----------------------------------------------------------------
   // channel map and temperature channel validity
   // ----------------------------------------------------------------
   wire [2:0] ch_port = ctrl0_q[C0_CHS_LSB + 3 +: 3];
   wire [2:0] ch_pin = ctrl0_q[C0_CHS_LSB +: 3];
   wire [5:0] chs = ctrl0_q[C0_CHS_LSB +: 6];
   wire ch_special = (chs == CH_GND) || (chs == CH_TEMP)
      || (chs == CH_DAC) || (chs == CH_FVR);
   wire ch_legal_d = ch_special || ((ch_port == PORT_E)
      ? (ch_pin < PINS_E)
      : ((ch_port <= PORT_F) && (ch_pin < PINS_MAIN))); // RQ5
   wire tvalid_d = (chs == CH_TEMP) && vref_q[VR_TEMP_INDICATOR_ENABLE_BIT]; // RQ21
   wire [1:0] pref = ctrl1_q[C1_PREF_LSB +: 2];

   // ----------------------------------------------------------------
   // divider hookup
   // ----------------------------------------------------------------
   assign tad.conv_clock_select = ctrl1_q[C1_CS_LSB +: 3]; // RQ9
   assign tad.restart = start; // RQ20

   act_tad_div u_div (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_rc_osc(i_rc_osc),
      .tad(tad)
   );

   // bus handshake and registered read data
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         ack_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ack_q <= req && !ack_q;
         if (i_avs_read && !ack_q) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // comparator and reference-ready pins cross in through two flops
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         cmp_m_q <= 1'b0;
         cmp_s_q <= 1'b0;
         rdy_m_q <= 1'b0;
         rdy_s_q <= 1'b0;
      end else begin
         cmp_m_q <= i_cmp_above;
         cmp_s_q <= cmp_m_q;
         rdy_m_q <= i_fvr_ready;
         rdy_s_q <= rdy_m_q;
      end
   end

   // software control registers
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         ctrl0_q <= CTRL0_RST;
         ctrl1_q <= CTRL1_RST;
         vref_q <= VREF_RST;
         ie_q <= 1'b0;
      end else begin
         if (wr_c0) begin
            ctrl0_q <= wdat & CTRL0_MASK; // RQ4
         end
         if (wr && hit_c1) begin
            ctrl1_q <= wdat & CTRL1_MASK;
         end
         if (wr && hit_vr) begin
            vref_q <= wdat & VREF_MASK; // RQ16
         end
         if (wr_irq) begin
            ie_q <= wdat[IRQ_IE_BIT];
         end
      end
   end

   // conversion sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               state_d = ST_CONVERT; // RQ17
            end
         end
         ST_CONVERT: begin
            if (done || abort) begin
               state_d = ST_IDLE; // RQ18
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // successive approximation: keep the trial bit if input is above
   always_comb begin
      sar_d = sar_q;
      if (start) begin
         sar_d = SAR_FIRST;
      end else if (decide) begin
         sar_d[bit_idx] = cmp_s_q; // RQ3
         if (bit_idx != 4'h0) begin
            sar_d[bit_idx - 4'h1] = 1'b1;
         end
      end
   end

   // sequencer state, half-period count, result and flag
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         state_q <= ST_IDLE;
         hc_q <= 5'h00;
         sar_q <= 10'h000;
         res_q <= 10'h000;
         flag_q <= 1'b0;
      end else begin
         state_q <= state_d;
         sar_q <= sar_d;
         if (start) begin
            hc_q <= 5'h00;
         end else if (busy && tad.half_tick) begin
            hc_q <= hc_q + 5'h01; // RQ10
         end
         if (done) begin
            res_q <= sar_q; // RQ18
         end
         // completion wins over a software clear in the same cycle
         flag_q <= done || (flag_q
            && !(wr_irq && wdat[IRQ_FLAG_BIT])); // RQ18
      end
   end

   // registered channel status
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         legal_q <= 1'b0;
         tvalid_q <= 1'b0;
      end else begin
         legal_q <= ch_legal_d;
         tvalid_q <= tvalid_d; // RQ21
      end
   end

   // ----------------------------------------------------------------
   // analog-side controls, all straight from registers except o_wake, which is also gated by i_sleep
   // ----------------------------------------------------------------
   assign o_chan_sel = chs; // RQ4
   assign o_chan_legal = legal_q;
   assign o_temp_valid = tvalid_q;
   assign o_sample = conv_on && !busy;
   assign o_sar_code = sar_q;
   // low-voltage parts have no 4x option and fall back to supply
   assign o_pos_ref_sel = (LOW_VOLTAGE_PART && pref == PREF_FVR4)
      ? PREF_VDD : pref; // RQ7
   assign o_neg_ref_sel = ctrl1_q[C1_NREF_BIT]; // RQ8
   assign o_fvr_enable = vref_q[VR_EN_BIT];
   assign o_conv_ref_gain = vref_q[VR_ADG_LSB +: 2];
   assign o_comp_ref_gain = vref_q[VR_CDG_LSB +: 2];
   assign o_temp_enable = vref_q[VR_TEMP_INDICATOR_ENABLE_BIT]; // RQ16
   assign o_temp_high_range = vref_q[VR_TEMP_RANGE_SELECT_BIT]; // RQ1 RQ2
   assign o_conv_active = busy;
   assign o_irq = flag_q && ie_q; // RQ11
   assign o_wake = flag_q && ie_q && i_sleep; // RQ11

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   sequence s_vref_write;
      wr && hit_vr;
   endsequence

   property p_range_high;
      (s_vref_write and wdat[VR_TEMP_RANGE_SELECT_BIT]) |=> o_temp_high_range;
   endproperty
   a_range_high: assert property (p_range_high) else $error("no high"); // RQ1

   property p_range_low;
      (s_vref_write and !wdat[VR_TEMP_RANGE_SELECT_BIT]) |=> !o_temp_high_range;
   endproperty
   a_range_low: assert property (p_range_low) else $error("no low"); // RQ2

   property p_temp_en;
      s_vref_write |=> (o_temp_enable == $past(wdat[VR_TEMP_INDICATOR_ENABLE_BIT]));
   endproperty
   a_temp_en: assert property (p_temp_en) else $error("temp_indicator_enable lost"); // RQ16

   property p_chan;
      wr_c0 |=> (o_chan_sel == $past(wdat[C0_CHS_LSB +: 6]));
   endproperty
   a_chan: assert property (p_chan) else $error("channel lost"); // RQ4

   property p_go_off;
      (wr_c0 && wdat[C0_GO_BIT] && !conv_on && !busy) |=> !busy;
   endproperty
   a_go_off: assert property (p_go_off) else $error("ran while off"); // RQ17

   sequence s_finish;
      !busy && flag_q && (res_q == $past(sar_q));
   endsequence
   property p_done;
      done |=> s_finish;
   endproperty
   a_done: assert property (p_done) else $error("bad completion"); // RQ18

   property p_length;
      done |-> (hc_q == 5'(HALF_TICKS - 1)) && $past(busy);
   endproperty
   a_length: assert property (p_length) else $error("bad length"); // RQ10

   property p_irq;
      (done && ie_q) |=> o_irq ##1 (o_irq || !flag_q);
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing"); // RQ11

   property p_right;
      (i_avs_read && !ack_q && hit_lo && fmt_right)
         |=> (o_avs_readdata[7:0] == $past(res_q[7:0]));
   endproperty
   a_right: assert property (p_right) else $error("bad justify"); // RQ19

   property p_tvalid;
      !vref_q[VR_TEMP_INDICATOR_ENABLE_BIT] |=> !o_temp_valid;
   endproperty
   a_tvalid: assert property (p_tvalid) else $error("temp valid"); // RQ21

endmodule

// ==== core/act_pkg.sv ====
// constants, field layout and types shared by the converter control block
package act_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_CTRL0 = 5'h00;
   localparam logic [4:0] OFS_CTRL1 = 5'h04;
   localparam logic [4:0] OFS_VREF = 5'h08;
   localparam logic [4:0] OFS_RES_HI = 5'h0c;
   localparam logic [4:0] OFS_RES_LO = 5'h10;
   localparam logic [4:0] OFS_IRQ = 5'h14;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int C0_ON_BIT = 0;
   localparam int C0_GO_BIT = 1;
   localparam int C0_CHS_LSB = 2;
   localparam int C1_PREF_LSB = 0;
   localparam int C1_NREF_BIT = 2;
   localparam int C1_CS_LSB = 4;
   localparam int C1_FM_BIT = 7;
   localparam int VR_ADG_LSB = 0;
   localparam int VR_CDG_LSB = 2;
   localparam int VR_TEMP_RANGE_SELECT_BIT = 4;
   localparam int VR_TEMP_INDICATOR_ENABLE_BIT = 5;
   localparam int VR_RDY_BIT = 6;
   localparam int VR_EN_BIT = 7;
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_IE_BIT = 1;

   // ----------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] VREF_RST = 8'h00;
   localparam logic [7:0] CTRL0_MASK = 8'hfd;
   localparam logic [7:0] CTRL1_MASK = 8'hf7;
   localparam logic [7:0] VREF_MASK = 8'hbf;

   // ----------------------------------------------------------------
   // converter timing and codes
   // ----------------------------------------------------------------
   localparam int RES_BITS = 10;
   // 11.5 converter clock periods counted in half periods
   localparam int HALF_TICKS = 23;
   localparam logic [4:0] HALF_LAST = 5'(HALF_TICKS - 1);
   localparam logic [4:0] HALF_LAST_BIT = 5'h13;
   localparam logic [9:0] SAR_FIRST = 10'h200;
   localparam logic [1:0] CS_RC_LOW = 2'h3;
   localparam logic [1:0] PREF_PIN = 2'h0;
   localparam logic [1:0] PREF_VDD = 2'h1;
   localparam logic [1:0] PREF_FVR2 = 2'h2;
   localparam logic [1:0] PREF_FVR4 = 2'h3;
   localparam logic LOW_VOLTAGE_PART = 1'b0;
   // channel map: ports a..f on chs[5:3] = 0..5, pin on chs[2:0]
   localparam logic [2:0] PORT_E = 3'h4;
   localparam logic [2:0] PORT_F = 3'h5;
   localparam logic [2:0] PINS_MAIN = 3'h7;
   localparam logic [2:0] PINS_E = 3'h3;
   localparam logic [5:0] CH_GND = 6'h3b;
   localparam logic [5:0] CH_TEMP = 6'h3c;
   localparam logic [5:0] CH_DAC = 6'h3d;
   localparam logic [5:0] CH_FVR = 6'h3e;

   typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} act_state_type;

endpackage

// ==== core/act_tad_div.sv ====
// converter clock divider: half-period ticks from system clock or rc osc
`timescale 1ns/1ps
module act_tad_div (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_rc_osc,
   act_tad_if.div tad
);
   import act_pkg::*;

   logic rc_m_q;
   logic rc_s_q;
   logic rc_d_q;
   logic [4:0] cnt_q;
   logic [2:0] shift;
   logic [4:0] reload;
   logic use_rc;
   logic sys_tick;
   logic rc_tick;

   // ----------------------------------------------------------------
   // rc oscillator pin synchroniser and edge history
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         rc_m_q <= 1'b0;
         rc_s_q <= 1'b0;
         rc_d_q <= 1'b0;
      end else begin
         rc_m_q <= i_rc_osc;
         rc_s_q <= rc_m_q;
         rc_d_q <= rc_s_q;
      end
   end

   // ----------------------------------------------------------------
   // ratio decode: 000 /2, 100 /4, 001 /8, 101 /16, 010 /32, 110 /64
   // ----------------------------------------------------------------
   assign use_rc = (tad.conv_clock_select[1:0] == CS_RC_LOW); // RQ9
   assign shift = 3'({tad.conv_clock_select[1:0], 1'b0})
      + 3'(tad.conv_clock_select[2]); // RQ9
   assign reload = 5'((6'h01 << shift) - 6'h01);

   // restarts with each conversion; a shorter ratio cuts a stale count
   always_ff @(posedge i_clock) begin
      if (!i_nrst || tad.restart) begin
         cnt_q <= reload; // RQ20
      end else if (cnt_q == 5'h00 || cnt_q > reload) begin
         cnt_q <= reload;
      end else begin
         cnt_q <= cnt_q - 5'h01;
      end
   end

   // both rc edges are half periods; rc never follows the system clock
   assign sys_tick = !tad.restart && (cnt_q == 5'h00); // RQ12
   assign rc_tick = !tad.restart && (rc_s_q ^ rc_d_q); // RQ12
   assign tad.half_tick = use_rc ? rc_tick : sys_tick;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   property p_div2;
      (tad.conv_clock_select == 3'b000 && !tad.restart)
         ##1 (tad.conv_clock_select == 3'b000 && !tad.restart)
         |-> tad.half_tick;
   endproperty
   a_div2: assert property (p_div2) else $error("div2 tick missing"); // RQ9

   sequence s_sel4_run;
      (tad.conv_clock_select == 3'b100 && !tad.restart);
   endsequence
   property p_div4;
      (s_sel4_run and tad.half_tick) ##1 s_sel4_run ##1 s_sel4_run
         |-> tad.half_tick && !$past(tad.half_tick);
   endproperty
   a_div4: assert property (p_div4) else $error("div4 spacing wrong"); // RQ9

   property p_rc_only;
      (use_rc && tad.half_tick) |-> (rc_s_q != rc_d_q);
   endproperty
   a_rc_only: assert property (p_rc_only) else $error("rc tick no edge"); // RQ12

   property p_restart;
      tad.restart |-> !tad.half_tick ##1 (cnt_q == $past(reload));
   endproperty
   a_restart: assert property (p_restart) else $error("no restart"); // RQ20

endmodule

// ==== core/act_tad_if.sv ====
// converter clock request and half-period tick between control and divider
`timescale 1ns/1ps
interface act_tad_if;
   logic [2:0] conv_clock_select;
   logic restart;
   logic half_tick;
   modport ctl (output conv_clock_select, output restart,
      input half_tick);
   modport div (input conv_clock_select, input restart,
      output half_tick);
endinterface

// ==== tb/act_adc_ctrl_tb.sv ====
// self-checking bench for the converter control register block
`timescale 1ns/1ps
module act_adc_ctrl_tb;
   import act_pkg::*;
   logic i_clock = 1'b0;
   logic i_nrst = 1'b0;
   logic [4:0] i_avs_address = 5'h00;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic i_rc_osc = 1'b0;
   logic i_cmp_above = 1'b0;
   logic i_fvr_ready = 1'b1;
   logic i_sleep = 1'b0;
   wire [31:0] o_avs_readdata;
   wire o_avs_waitrequest, o_chan_legal, o_sample, o_neg_ref_sel;
   wire o_fvr_enable, o_temp_enable, o_temp_high_range, o_temp_valid;
   wire o_conv_active, o_irq, o_wake;
   wire [5:0] o_chan_sel;
   wire [9:0] o_sar_code;
   wire [1:0] o_pos_ref_sel, o_conv_ref_gain, o_comp_ref_gain;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int last_cyc = 0;
   logic [9:0] analog_v = 10'h000;
   logic [31:0] rd;
   logic [7:0] d;
   logic [5:0] ch;
   int acc = 0;
   int q[$];
   int ratio_t[6] = '{2, 4, 8, 16, 32, 64};
   logic [2:0] sel_t[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};

   act_adc_ctrl act_adc_ctrl_i (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_rc_osc(i_rc_osc),
      .i_cmp_above(i_cmp_above), .i_fvr_ready(i_fvr_ready),
      .i_sleep(i_sleep), .o_chan_sel(o_chan_sel),
      .o_chan_legal(o_chan_legal), .o_sample(o_sample),
      .o_sar_code(o_sar_code), .o_pos_ref_sel(o_pos_ref_sel),
      .o_neg_ref_sel(o_neg_ref_sel), .o_fvr_enable(o_fvr_enable),
      .o_conv_ref_gain(o_conv_ref_gain), .o_comp_ref_gain(o_comp_ref_gain),
      .o_temp_enable(o_temp_enable), .o_temp_high_range(o_temp_high_range),
      .o_temp_valid(o_temp_valid), .o_conv_active(o_conv_active),
      .o_irq(o_irq), .o_wake(o_wake));

   // ----------------------------------------
   // models and tasks
   // ----------------------------------------
   always #5 i_clock = ~i_clock;

   // cycle stamp, comparator as analog_v plus half a code, slow rc pin
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      i_cmp_above <= (analog_v >= o_sar_code);
      if (cyc % 7 == 0) begin
         i_rc_osc <= ~i_rc_osc;
      end
   end

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // channel codes that exist on the largest part
   function automatic logic legal(input logic [5:0] c);
      if (c >= CH_GND && c <= CH_FVR) return 1'b1;
      if (c[5:3] == PORT_E) return c[2:0] < PINS_E;
      return c[5:3] <= PORT_F && c[2:0] < PINS_MAIN;
   endfunction

   // result pair as software sees it; 1 = right justified
   function automatic logic [15:0] fmt(input logic f, input logic [9:0] v);
      return f ? {6'h00, v} : {v, 6'h00};
   endfunction

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a,
      input logic [7:0] dat);
      int n;
      n = 0;
      i_avs_address <= a;
      i_avs_write <= wr;
      i_avs_read <= ~wr;
      i_avs_writedata <= {24'h000000, dat};
      do begin
         @(posedge i_clock);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 20);
      check("wait states", n, 2);
      rd = o_avs_readdata;
      last_cyc = cyc;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      @(posedge i_clock);
   endtask

   task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00);
      check("register read", rd, exp);
   endtask

   // start a conversion on channel ch; go-to-idle span must fit lo..hi
   task automatic convert(input int lo, input int hi);
      int n;
      n = 0;
      bus(1'b1, OFS_CTRL0, {ch, 2'b01});
      check("sample tracking", o_sample, 1'b1);
      repeat (4) @(posedge i_clock);
      bus(1'b1, OFS_CTRL0, {ch, 2'b11});
      check("busy", o_conv_active, 1'b1);
      check("sample hold", o_sample, 1'b0);
      while (o_conv_active === 1'b1 && n < 2000) begin
         @(posedge i_clock);
         n++;
      end
      n = cyc - last_cyc;
      check("conversion span", n >= lo && n <= hi, 1'b1);
      check("irq level", o_irq, 1'b1);
      rdchk(OFS_CTRL0, {24'h0, ch, 2'b01});
      rdchk(OFS_IRQ, 32'h3);
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // watchdog well beyond the expected few thousand cycles
   initial begin
      #(50000 * 10);
      n_errors++;
      finish_test();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      void'($urandom(42992));
      repeat (12) @(posedge i_clock);
      i_nrst <= 1'b1;
      @(posedge i_clock);
      rdchk(OFS_CTRL0, 32'h0);
      rdchk(OFS_CTRL1, 32'h0);
      rdchk(OFS_VREF, 32'h40);
      rdchk(5'h18, 32'h0);
      // channel field and existence map, then the reference selects
      for (int i = 0; i < 20; i++) begin
         ch = (i < 5) ? CH_GND + 6'(i) : 6'($urandom);
         bus(1'b1, OFS_CTRL0, {ch, 2'b00});
         @(posedge i_clock);
         check("channel", o_chan_sel, ch);
         check("channel legal", o_chan_legal, legal(ch));
         d = 8'($urandom);
         d[1:0] = 2'(i);
         bus(1'b1, OFS_CTRL1, d);
         check("pos ref", o_pos_ref_sel, d[1:0]);
         check("neg ref", o_neg_ref_sel, d[2]);
         rdchk(OFS_CTRL1, {24'h0, d & CTRL1_MASK});
      end
      // indicator enable and range with the temperature channel selected
      ch = CH_TEMP;
      bus(1'b1, OFS_CTRL0, {ch, 2'b00});
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         d[5:4] = 2'(i);
         bus(1'b1, OFS_VREF, d);
         check("high range", o_temp_high_range, d[4]);
         check("temp enable", o_temp_enable, d[5]);
         check("gains", {o_comp_ref_gain, o_conv_ref_gain}, d[3:0]);
         check("fvr enable", o_fvr_enable, d[7]);
         @(posedge i_clock);
         check("temp valid", o_temp_valid, d[5]);
         rdchk(OFS_VREF, {24'h0, (d & VREF_MASK) | 8'h40});
      end
      // go while off is ignored
      bus(1'b1, OFS_CTRL0, 8'h00);
      bus(1'b1, OFS_CTRL0, 8'h02);
      check("go while off", o_conv_active, 1'b0);
      // every divided clock, both result formats, interrupt and wake
      bus(1'b1, OFS_IRQ, 8'h02);
      ch = 6'h05;
      for (int i = 0; i < 8; i++) begin
         analog_v = 10'($urandom);
         d = {i[0], (i < 6) ? sel_t[i] : {i[2], 2'b11}, 4'h0};
         bus(1'b1, OFS_CTRL1, d);
         if (i < 6) begin
            convert(23 * ratio_t[i] / 2 + 1, 23 * ratio_t[i] / 2 + 1);
         end else begin
            convert(22 * 7, 24 * 7 + 4);
         end
         if (i > 1) begin
            rdchk(OFS_RES_HI, fmt(d[7], analog_v) >> 8);
            rdchk(OFS_RES_LO, fmt(d[7], analog_v) & 16'hff);
         end
         i_sleep <= 1'b1;
         @(posedge i_clock);
         check("wake", o_wake, 1'b1);
         i_sleep <= 1'b0;
         bus(1'b1, OFS_IRQ, 8'h03);
         check("irq cleared", o_irq, 1'b0);
      end
      // ground first, settle, then ten temperature readings averaged
      bus(1'b1, OFS_VREF, 8'h20);
      bus(1'b1, OFS_CTRL1, 8'h90);
      ch = CH_GND;
      analog_v = 10'h000;
      convert(93, 93);
      ch = CH_TEMP;
      for (int i = 0; i < 10; i++) begin
         analog_v = 10'h140 + 10'($urandom % 64);
         q.push_back(int'(analog_v));
         convert(93, 93);
         check("temp valid", o_temp_valid, 1'b1);
         rdchk(OFS_RES_LO, analog_v[7:0]);
         acc += int'(rd[7:0]);
         rdchk(OFS_RES_HI, analog_v[9:8]);
         acc += int'(rd[1:0]) * 256;
      end
      check("temp average", acc / 10, q.sum() / 10);
      // sleep with a divided clock cuts a running conversion short
      bus(1'b1, OFS_CTRL1, 8'h60);
      bus(1'b1, OFS_CTRL0, {ch, 2'b11});
      check("busy", o_conv_active, 1'b1);
      i_sleep <= 1'b1;
      @(posedge i_clock);
      i_sleep <= 1'b0;
      @(posedge i_clock);
      check("sleep abort", o_conv_active, 1'b0);
      finish_test();
   end
endmodule
